// ==== rtl/tbd_regs.svh ====
// register offsets, field positions and decode constants for the texel decoder
`ifndef TBD_REGS_SVH
`define TBD_REGS_SVH

// ---------------------------------------------------------------
// register map (byte addresses, low address bits only)
// ---------------------------------------------------------------
`define TBD_ADDR_W 8
`define TBD_OFS_BLOCK 8'h00
`define TBD_OFS_CTRL 8'h10
`define TBD_OFS_STATUS 8'h14
`define TBD_OFS_RESULT 8'h18

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TBD_CTRL_START_BIT 8
`define TBD_STAT_PENDING_BIT 0
`define TBD_STAT_DONE_BIT 1
`define TBD_STAT_UNSUPP_BIT 4

// ---------------------------------------------------------------
// decode constants and timing
// ---------------------------------------------------------------
`define TBD_ALPHA_OPAQUE 8'hFF
`define TBD_HI_STEPS 3'h6
`define TBD_HI_CLEAR_IDX 3'h7
`define TBD_HI_BIAS 11'h003
`define TBD_HI_DIV 11'h006
`define TBD_THIRD_BIAS 10'h001
`define TBD_THIRD_DIV 10'h003
`define TBD_RSP_LATENCY 2

`endif

// ==== rtl/tbd_pkg.sv ====
// types shared by the texel decoder modules
package tbd_pkg;

	// block compression modes, taken from the top bits of a block
	typedef enum logic [1:0] {
		hi_mode,
		chroma_mode,
		three_colour_alpha_mode,
		mixed_mode
	} tbd_mode_t;

	// expanded colour: [2] red, [1] green, [0] blue
	typedef logic [2:0][7:0] tbd_rgb_t;

endpackage : tbd_pkg

// ==== rtl/tbd_reg_if.sv ====
// carrier between the register slave and the decode core
`timescale 1ns/10ps
interface tbd_reg_if;
	logic [127:0] blk;
	logic [4:0] texel;
	logic start;
	logic [31:0] result;
	logic done;
	logic pending;
	logic unsupp;
	logic [1:0] mode;

	modport regs (
		output blk, texel, start,
		input result, done, pending, unsupp, mode
	);
	modport core (
		input blk, texel, start,
		output result, done, pending, unsupp, mode
	);
endinterface : tbd_reg_if

// ==== rtl/tbd_ahb_regs.sv ====
// AHB-Lite register slave for the texel decoder
`timescale 1ns/10ps
`include "tbd_regs.svh"
module tbd_ahb_regs import tbd_pkg::*; (
	input wire logic clk_i,              // system clock
	input wire logic rst_b_i,            // synchronous reset, low
	input wire logic hsel_i,             // slave select
	input wire logic [31:0] haddr_i,     // address
	input wire logic [1:0] htrans_i,     // transfer type
	input wire logic hwrite_i,           // write not read
	input wire logic [2:0] hsize_i,      // transfer size
	input wire logic [31:0] hwdata_i,    // write data
	input wire logic hready_i,           // bus ready
	output logic [31:0] hrdata_o,        // read data
	output logic hreadyout_o,            // slave ready
	output logic hresp_o,                // response
	tbd_reg_if.regs ri                   // toward decode core
);

	// ---------------------------------------------------------------
	// address phase capture
	// ---------------------------------------------------------------
	logic act_q;
	logic wr_q;
	logic [`TBD_ADDR_W-1:0] addr_q;
	logic [3:0][31:0] blk_q;
	logic [4:0] texel_q;
	logic start_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;

	// only whole words are used; hsize is accepted but not checked
	wire logic addr_ok = hsel_i & hready_i & htrans_i[1];
	wire logic [`TBD_ADDR_W-1:0] a_w = haddr_i[`TBD_ADDR_W-1:0];
	wire logic [`TBD_ADDR_W-1:0] aw_w = {a_w[`TBD_ADDR_W-1:2], 2'h0};
	wire logic we_w = act_q & wr_q;
	wire logic we_blk = we_w & (addr_q[7:4] == 4'h0);
	wire logic we_ctrl = we_w & ({addr_q[7:2], 2'h0} == `TBD_OFS_CTRL);
	wire logic unused_w = ^hsize_i;

	// ---------------------------------------------------------------
	// read selection, unmapped words read zero
	// ---------------------------------------------------------------
	wire logic [31:0] stat_w = {27'h0, ri.unsupp, ri.mode, ri.done,
		ri.pending};
	wire logic [31:0] rd_w =
		(a_w[7:4] == 4'h0) ? blk_q[a_w[3:2]] :
		(aw_w == `TBD_OFS_CTRL) ? {27'h0, texel_q} :
		(aw_w == `TBD_OFS_STATUS) ? stat_w :
		(aw_w == `TBD_OFS_RESULT) ? ri.result : 32'h0;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			act_q <= 1'b0;
			wr_q <= 1'b0;
			addr_q <= '0;
			hrdata_q <= 32'h0;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			act_q <= addr_ok;
			wr_q <= hwrite_i & ~unused_w | hwrite_i;
			addr_q <= a_w;
			if (addr_ok && !hwrite_i) begin
				hrdata_q <= rd_w;
			end
		end
	end

	// ---------------------------------------------------------------
	// data phase writes
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			blk_q <= '0;
			texel_q <= 5'h00;
			start_q <= 1'b0;
		end else begin
			start_q <= we_ctrl & hwdata_i[`TBD_CTRL_START_BIT];
			if (we_blk) begin
				blk_q[addr_q[3:2]] <= hwdata_i;
			end
			if (we_ctrl) begin
				texel_q <= hwdata_i[4:0];
			end
		end
	end

	assign ri.blk = blk_q;
	assign ri.texel = texel_q;
	assign ri.start = start_q;
	assign hrdata_o = hrdata_q;
	assign hreadyout_o = hreadyout_q;
	assign hresp_o = hresp_q;

endmodule : tbd_ahb_regs

// ==== rtl/tbd_top.sv ====
// texture block decoder: block plus texel number in, ARGB colour out
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "tbd_regs.svh"
// Function
// - two-colour mode: fields and 3-bit indices
// - widen 5-bit channels by top-bit replication
// - eight entries, sixths with rounding, entry 7 clear
// - 3-bit index selects entry, output ARGB
// - four-colour mode: fields, bit 124 ignored
// - widen all four colours the same way
// - index picks colour directly, alpha opaque
// - mixed mode: green LSBs and variant bit
// - bit 124 chooses mixed decoding variant
// - variant zero: 565 colours, derived green LSBs
// - variant zero: widen 5 and 6-bit channels
// - texels 0-15 low pair, 16-31 high pair
// - low half, variant zero: thirds table, alpha opaque
// - high half, variant zero: thirds table, alpha opaque
// - 32 texels as two 4x4 tiles
// - three-colour alpha mode detected, not decoded
// - variant one: average entry, index 3 clear
module tbd_top import tbd_pkg::*; (
	input wire logic CLK_SYS_I,             // system clock
	input wire logic RST_B_I,               // synchronous reset, low
	input wire logic HSEL_I,                // slave select
	input wire logic [31:0] HADDR_I,        // address
	input wire logic [1:0] HTRANS_I,        // transfer type
	input wire logic HWRITE_I,              // write not read
	input wire logic [2:0] HSIZE_I,         // transfer size
	input wire logic [31:0] HWDATA_I,       // write data
	input wire logic HREADY_I,              // bus ready
	output logic [31:0] HRDATA_O,           // read data
	output logic HREADYOUT_O,               // slave ready
	output logic HRESP_O,                   // response, always okay
	input wire logic REQ_VALID_I,           // request strobe
	input wire logic [127:0] REQ_BLOCK_I,   // compressed block
	input wire logic [4:0] REQ_TEXEL_I,     // texel number
	output logic RSP_VALID_O,               // answer strobe
	output logic [31:0] RSP_COLOUR_O,       // ARGB colour
	output logic [1:0] RSP_MODE_O,          // block mode
	output logic RSP_UNSUPP_O               // mode not decoded
);

	// ---------------------------------------------------------------
	// channel widening and interpolation helpers
	// ---------------------------------------------------------------
	function automatic tbd_rgb_t exp555(input logic [14:0] c);
		exp555 = {{c[14:10], c[14:12]}, {c[9:5], c[9:7]},
			{c[4:0], c[4:2]}};
	endfunction : exp555

	function automatic tbd_rgb_t exp565(input logic [4:0] r,
		input logic [5:0] g, input logic [4:0] b);
		exp565 = {{r, r[4:2]}, {g, g[5:4]}, {b, b[4:2]}};
	endfunction : exp565

	function automatic tbd_rgb_t interpolate_select_sixth(input tbd_rgb_t c0,
		input tbd_rgb_t c1, input logic [2:0] i);
		logic [10:0] w0;
		logic [10:0] w1;
		logic [10:0] s;
		interpolate_select_sixth = '0;
		w0 = {8'h00, 3'(`TBD_HI_STEPS - i)};
		w1 = {8'h00, i};
		for (int k = 0; k < 3; k++) begin
			s = w0 * {3'h0, c0[k]} + w1 * {3'h0, c1[k]} + `TBD_HI_BIAS;
			interpolate_select_sixth[k] = 8'(s / `TBD_HI_DIV);
		end
	endfunction : interpolate_select_sixth

	// (2a + b + 1) / 3 per channel
	function automatic tbd_rgb_t third(input tbd_rgb_t a,
		input tbd_rgb_t b);
		logic [9:0] s;
		third = '0;
		for (int k = 0; k < 3; k++) begin
			s = {1'b0, a[k], 1'b0} + {2'h0, b[k]} + `TBD_THIRD_BIAS;
			third[k] = 8'(s / `TBD_THIRD_DIV);
		end
	endfunction : third

	// truncating average per channel
	function automatic tbd_rgb_t avg(input tbd_rgb_t a,
		input tbd_rgb_t b);
		logic [8:0] s;
		avg = '0;
		for (int k = 0; k < 3; k++) begin
			s = {1'b0, a[k]} + {1'b0, b[k]};
			avg[k] = s[8:1];
		end
	endfunction : avg

	// ---------------------------------------------------------------
	// register slave
	// ---------------------------------------------------------------
	tbd_reg_if ri ();

	tbd_ahb_regs u_regs (
		.clk_i(CLK_SYS_I),
		.rst_b_i(RST_B_I),
		.hsel_i(HSEL_I),
		.haddr_i(HADDR_I),
		.htrans_i(HTRANS_I),
		.hwrite_i(HWRITE_I),
		.hsize_i(HSIZE_I),
		.hwdata_i(HWDATA_I),
		.hready_i(HREADY_I),
		.hrdata_o(HRDATA_O),
		.hreadyout_o(HREADYOUT_O),
		.hresp_o(HRESP_O),
		.ri(ri.regs)
	);

	// ---------------------------------------------------------------
	// request stage
	// ---------------------------------------------------------------
	logic sw_pending_q;
	logic s1_valid_q;
	logic s1_sw_q;
	logic [127:0] s1_block_q;
	logic [4:0] s1_texel_q;

	// the port has priority; a software request waits for a free slot
	wire logic issue_sw = sw_pending_q & ~REQ_VALID_I;
	// limitation: a steady stream of port requests holds software off
	// whole block is copied so one answer never mixes two requests

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I) begin
			sw_pending_q <= 1'b0;
			s1_valid_q <= 1'b0;
			s1_sw_q <= 1'b0;
			s1_block_q <= '0;
			s1_texel_q <= 5'h00;
		end else begin
			sw_pending_q <= ri.start | (sw_pending_q & ~issue_sw);
			s1_valid_q <= REQ_VALID_I | issue_sw;
			s1_sw_q <= issue_sw;
			if (REQ_VALID_I) begin
				s1_block_q <= REQ_BLOCK_I;
				s1_texel_q <= REQ_TEXEL_I;
			end else if (issue_sw) begin
				s1_block_q <= ri.blk;
				s1_texel_q <= ri.texel;
			end
		end
	end

	// ---------------------------------------------------------------
	// mode and index extraction
	// ---------------------------------------------------------------
	wire logic [127:0] blk = s1_block_q;
	// texel[4] picks the tile, texel[3:0] the row-ordered place in it
	wire logic upper_tile = s1_texel_q[4];
	wire logic [6:0] pos3 = 7'({s1_texel_q, 1'b0}) + 7'(s1_texel_q);
	wire logic [6:0] pos2 = 7'({s1_texel_q, 1'b0});
	wire logic [2:0] idx3 = blk[pos3 +: 3];
	wire logic [1:0] idx2 = blk[pos2 +: 2];
	wire logic variant1 = blk[124];

	wire tbd_mode_t mode_w = blk[127] ? mixed_mode :
		!blk[126] ? hi_mode :
		blk[125] ? three_colour_alpha_mode : chroma_mode;
	wire logic is_hi = (mode_w == hi_mode);
	wire logic is_chroma = (mode_w == chroma_mode);
	wire logic is_mixed = (mode_w == mixed_mode);

	// ---------------------------------------------------------------
	// two-colour eight-entry mode
	// ---------------------------------------------------------------
	wire tbd_rgb_t hi_c1 = exp555(blk[125:111]);
	wire tbd_rgb_t hi_c0 = exp555(blk[110:96]);
	wire tbd_rgb_t hi_rgb = interpolate_select_sixth(hi_c0, hi_c1, idx3);
	// entry 7 is transparent black, not a blend of the two colours
	wire logic hi_clear = (idx3 == `TBD_HI_CLEAR_IDX);
	wire logic [31:0] hi_col = hi_clear ? 32'h0 :
		{`TBD_ALPHA_OPAQUE, hi_rgb};

	// ---------------------------------------------------------------
	// four-colour direct mode, bit 124 unused
	// ---------------------------------------------------------------
	wire tbd_rgb_t ch_c3 = exp555(blk[123:109]);
	wire tbd_rgb_t ch_c2 = exp555(blk[108:94]);
	wire tbd_rgb_t ch_c1 = exp555(blk[93:79]);
	wire tbd_rgb_t ch_c0 = exp555(blk[78:64]);
	wire tbd_rgb_t ch_rgb = (idx2 == 2'h0) ? ch_c0 :
		(idx2 == 2'h1) ? ch_c1 :
		(idx2 == 2'h2) ? ch_c2 : ch_c3;
	wire logic [31:0] ch_col = {`TBD_ALPHA_OPAQUE, ch_rgb};

	// ---------------------------------------------------------------
	// mixed mode
	// ---------------------------------------------------------------
	// odd colours always carry an explicit green LSB
	wire tbd_rgb_t mx_c3 = exp565(blk[123:119],
		{blk[118:114], blk[126]}, blk[113:109]);
	wire tbd_rgb_t mx_c1 = exp565(blk[93:89],
		{blk[88:84], blk[125]}, blk[83:79]);
	// even colours borrow an index bit in variant zero
	wire tbd_rgb_t mx_c2_565 = exp565(blk[108:104],
		{blk[103:99], blk[33] ^ blk[126]}, blk[98:94]);
	wire tbd_rgb_t mx_c0_565 = exp565(blk[78:74],
		{blk[73:69], blk[1] ^ blk[125]}, blk[68:64]);
	// variant one keeps the even colours at five bits per channel
	wire tbd_rgb_t mx_c2 = variant1 ? exp555(blk[108:94]) :
		mx_c2_565;
	wire tbd_rgb_t mx_c0 = variant1 ? exp555(blk[78:64]) :
		mx_c0_565;
	wire tbd_rgb_t mx_a = upper_tile ? mx_c2 : mx_c0;
	wire tbd_rgb_t mx_b = upper_tile ? mx_c3 : mx_c1;

	// one set of dividers serves both tiles, the tile picks the pair
	wire tbd_rgb_t mx_near_a = third(mx_a, mx_b);
	wire tbd_rgb_t mx_near_b = third(mx_b, mx_a);
	wire tbd_rgb_t mx_mid = avg(mx_a, mx_b);

	wire tbd_rgb_t mx_v0_rgb = (idx2 == 2'h0) ? mx_a :
		(idx2 == 2'h1) ? mx_near_a :
		(idx2 == 2'h2) ? mx_near_b : mx_b;
	wire logic [31:0] mx_v0_col = {`TBD_ALPHA_OPAQUE, mx_v0_rgb};

	wire tbd_rgb_t mx_v1_rgb = (idx2 == 2'h0) ? mx_a :
		(idx2 == 2'h1) ? mx_mid : mx_b;
	wire logic [31:0] mx_v1_col = (idx2 == 2'h3) ? 32'h0 :
		{`TBD_ALPHA_OPAQUE, mx_v1_rgb};

	wire logic [31:0] mx_col = variant1 ? mx_v1_col : mx_v0_col;

	// ---------------------------------------------------------------
	// final selection
	// ---------------------------------------------------------------
	// alpha mode is only flagged; it answers transparent black
	wire logic unsupp_w = (mode_w == three_colour_alpha_mode);
	wire logic [31:0] col_w =
		is_hi ? hi_col :
		is_chroma ? ch_col :
		is_mixed ? mx_col : 32'h0;

	// ---------------------------------------------------------------
	// answer stage and software result
	// ---------------------------------------------------------------
	logic rsp_valid_q;
	logic [31:0] rsp_colour_q;
	logic [1:0] rsp_mode_q;
	logic rsp_unsupp_q;
	logic sw_done_q;
	logic [31:0] sw_result_q;
	logic [1:0] sw_mode_q;
	logic sw_unsupp_q;

	// answers leave two edges after the request, one edge per stage
	wire logic port_finish = s1_valid_q & ~s1_sw_q;
	wire logic sw_finish = s1_valid_q & s1_sw_q;

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I) begin
			rsp_valid_q <= 1'b0;
			rsp_colour_q <= 32'h0;
			rsp_mode_q <= 2'h0;
			rsp_unsupp_q <= 1'b0;
		end else begin
			// software requests stay off the port strobe
			rsp_valid_q <= port_finish;
			if (port_finish) begin
				rsp_colour_q <= col_w;
				rsp_mode_q <= 2'(mode_w);
				rsp_unsupp_q <= unsupp_w;
			end
		end
	end

	// ---------------------------------------------------------------
	// software result, kept apart from the port answer
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I) begin
			sw_done_q <= 1'b0;
			sw_result_q <= 32'h0;
			sw_mode_q <= 2'h0;
			sw_unsupp_q <= 1'b0;
		end else begin
			// a finish in the same cycle as a new start still sets done
			sw_done_q <= sw_finish | (sw_done_q & ~ri.start);
			if (sw_finish) begin
				sw_result_q <= col_w;
				sw_mode_q <= 2'(mode_w);
				sw_unsupp_q <= unsupp_w;
			end
		end
	end

	assign ri.result = sw_result_q;
	assign ri.done = sw_done_q;
	assign ri.pending = sw_pending_q | (s1_valid_q & s1_sw_q);
	assign ri.unsupp = sw_unsupp_q;
	assign ri.mode = sw_mode_q;

	assign RSP_VALID_O = rsp_valid_q;
	assign RSP_COLOUR_O = rsp_colour_q;
	assign RSP_MODE_O = rsp_mode_q;
	assign RSP_UNSUPP_O = rsp_unsupp_q;

endmodule : tbd_top

// ==== dv/tbd_chk.sv ====
// checker on the decoder's request port
`timescale 1ns/10ps
module tbd_chk (
	input wire logic CLK_SYS_I, // clock
	input wire logic RST_B_I, // reset, low
	input wire logic REQ_VALID_I, // request strobe
	input wire logic [127:0] REQ_BLOCK_I, // block
	input wire logic [4:0] REQ_TEXEL_I, // texel number
	input wire logic RSP_VALID_O, // answer strobe
	input wire logic [31:0] RSP_COLOUR_O, // colour
	input wire logic [1:0] RSP_MODE_O, // mode
	input wire logic RSP_UNSUPP_O // not decoded
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_B_I);
	// ---------------------------------------------------------------
	// request decode
	// ---------------------------------------------------------------
	wire [127:0] b = REQ_BLOCK_I;
	wire [2:0] ix = b[REQ_TEXEL_I*3 +: 3];
	wire [1:0] sel = b[REQ_TEXEL_I*2 +: 2];
	wire hi = REQ_VALID_I && b[127:126] == 2'h0;
	wire mix = REQ_VALID_I && b[127];
	wire chr = REQ_VALID_I && b[127:125] == 3'h2;
	wire [31:0] c0 = {8'hFF, b[78:74], b[78:76], b[73:69], b[73:71],
		b[68:64], b[68:66]};
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	chk_rsp_latency: assert property (REQ_VALID_I |-> ##2 RSP_VALID_O)
		else $error("answer missing two cycles after request");
	chk_rsp_cause: assert property (RSP_VALID_O |-> $past(REQ_VALID_I, 2))
		else $error("answer without request");
	chk_rsp_hold: assert property (!RSP_VALID_O |-> $stable(RSP_COLOUR_O))
		else $error("colour changed without answer");
	chk_hi_clear: assert property (hi && ix == 3'h7 |-> ##2 RSP_COLOUR_O == 32'h0 && RSP_MODE_O == 2'h0)
		else $error("last two-colour entry not clear");
	chk_hi_opaque: assert property (hi && ix != 3'h7 |-> ##2 RSP_COLOUR_O[31:24] == 8'hFF)
		else $error("two-colour entry not opaque");
	chk_chroma_pick: assert property (chr && sel == 2'h0 |-> ##2 RSP_COLOUR_O == $past(c0, 2) && RSP_MODE_O == 2'h1)
		else $error("four-colour index zero wrong");
	chk_mix_mode: assert property (mix |-> ##2 RSP_MODE_O == 2'h3 && !RSP_UNSUPP_O)
		else $error("mixed block mode wrong");
	chk_mix_opaque: assert property (mix && !b[124] |-> ##2 RSP_COLOUR_O[31:24] == 8'hFF)
		else $error("mixed variant zero not opaque");
	chk_mix_clear: assert property (mix && b[124] && sel == 2'h3 |-> ##2 RSP_COLOUR_O == 32'h0)
		else $error("mixed variant one index three not clear");
	chk_alpha_flag: assert property (REQ_VALID_I && b[127:125] == 3'h3 |-> ##2 RSP_UNSUPP_O && RSP_COLOUR_O == 32'h0)
		else $error("alpha block not flagged");
endmodule : tbd_chk

// ==== dv/tbd_smp_model.sv ====
// texel requester model on the far side of the request port
`timescale 1ns/10ps
module tbd_smp_model (
	input wire logic clk_i, // system clock
	input wire logic rsp_valid_i, // answer strobe
	input wire logic [34:0] rsp_i, // unsupp, mode, colour
	output logic req_valid_o, // request strobe
	output logic [127:0] req_block_o, // block
	output logic [4:0] req_texel_o // texel number
);
	logic [34:0] got_q[$];
	initial begin
		req_valid_o = 1'b0;
		req_block_o = '0;
		req_texel_o = '0;
	end
	// one request, held over exactly one sampling edge
	task automatic send(input logic [127:0] b, input logic [4:0] t);
		req_valid_o <= 1'b1;
		req_block_o <= b;
		req_texel_o <= t;
		@(posedge clk_i);
	endtask : send
	// released lines show the inverse, so stale values cannot match
	task automatic idle(input int n);
		req_valid_o <= 1'b0;
		req_block_o <= ~req_block_o;
		req_texel_o <= ~req_texel_o;
		repeat (n) @(posedge clk_i);
	endtask : idle
	always @(posedge clk_i) begin
		if (rsp_valid_i) got_q.push_back(rsp_i);
	end
endmodule : tbd_smp_model

// ==== dv/texture_block_decoder_test.sv ====
// self-checking bench for the texture block decoder
`timescale 1ns/10ps
`include "tbd_regs.svh"
module texture_block_decoder_test;
	logic clk, rst_b, hsel, hwrite, hready, hresp, rv, sv, su;
	logic [1:0] htrans, sm;
	logic [31:0] haddr, hwdata, hrdata, sc;
	logic [127:0] rb;
	logic [4:0] rt;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	tbd_top i_dut (.CLK_SYS_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel),
		.HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
		.HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
		.HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
		.REQ_VALID_I(rv), .REQ_BLOCK_I(rb), .REQ_TEXEL_I(rt),
		.RSP_VALID_O(sv), .RSP_COLOUR_O(sc), .RSP_MODE_O(sm),
		.RSP_UNSUPP_O(su));
	tbd_smp_model i_smp (.clk_i(clk), .rsp_valid_i(sv),
		.rsp_i({su, sm, sc}), .req_valid_o(rv), .req_block_o(rb),
		.req_texel_o(rt));
	// ---------------------------------------------------------------
	// reference decode
	// ---------------------------------------------------------------
	function automatic logic [7:0] x5(input logic [4:0] v);
		return {v, v[4:2]};
	endfunction : x5
	function automatic logic [31:0] ref_col(input logic [127:0] b,
		input logic [4:0] t);
		logic [7:0] c[4][3];
		logic [3:0] g;
		logic [1:0] s;
		logic [2:0] x;
		int a, d, k, j;
		logic [31:0] r;
		for (k = 0; k < 4; k++)
			for (j = 0; j < 3; j++)
				c[k][j] = x5(b[74+15*k-5*j +: 5]);
		s = b[2*t +: 2];
		x = b[3*t +: 3];
		r = 32'hFF000000;
		if (b[127:126] == 2'h0) begin
			if (x == 3'h7) return 32'h0;
			for (j = 0; j < 3; j++)
				r[16-8*j +: 8] = 8'(((6 - x) * x5(b[106-5*j +: 5])
					+ x * x5(b[121-5*j +: 5]) + 3) / 6);
			return r;
		end
		if (b[127:125] == 3'h3) return 32'h0;
		if (b[127:125] == 3'h2) return {8'hFF, c[s][0], c[s][1], c[s][2]};
		g = {b[126], b[33] ^ b[126], b[125], b[1] ^ b[125]};
		for (k = 0; k < 4; k++) begin
			x = 3'(k);
			if (!b[124] || x[0]) begin
				a = {b[69+15*k +: 5], g[k]};
				c[k][1] = {6'(a), a[5:4]};
			end
		end
		k = t[4] ? 2 : 0;
		for (j = 0; j < 3; j++) begin
			a = c[k][j];
			d = c[k+1][j];
			if (!b[124])
				r[16-8*j +: 8] = 8'(s == 0 ? a : s == 1 ? (2*a + d + 1) / 3 :
					s == 2 ? (a + 2*d + 1) / 3 : d);
			else
				r[16-8*j +: 8] = 8'(s == 0 ? a : s == 1 ? (a + d) / 2 :
					s == 2 ? d : 0);
		end
		if (b[124] && s == 2'h3) r = 32'h0;
		return r;
	endfunction : ref_col
	function automatic logic [127:0] idx2(input logic [63:0] hi_w,
		input logic [1:0] k);
		logic [127:0] b;
		b = {hi_w, 64'h0};
		for (int t = 0; t < 32; t++) b[2*t +: 2] = 2'(t) ^ k;
		return b;
	endfunction : idx2
	// ---------------------------------------------------------------
	// checking and bus tasks
	// ---------------------------------------------------------------
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
		cmp({31'h0, hresp}, 32'h0);
	endtask : bus
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		cmp(r, e);
	endtask : rd
	task automatic go(input logic [127:0] b, input int gap);
		logic [34:0] q;
		logic [31:0] m;
		m = b[127] ? 32'h3 : b[126] ? (b[125] ? 32'h6 : 32'h1) : 32'h0;
		for (int t = 0; t < 32; t++) begin
			i_smp.send(b, 5'(t));
			if (gap > 0) i_smp.idle(gap);
		end
		i_smp.idle(4);
		cmp(32'(i_smp.got_q.size()), 32'h20);
		for (int t = 0; t < 32 && i_smp.got_q.size() > 0; t++) begin
			q = i_smp.got_q.pop_front();
			cmp(q[31:0], ref_col(b, 5'(t)));
			cmp({29'h0, q[34:32]}, m);
		end
	endtask : go
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic s_hi;
		logic [127:0] b;
		b = {32'h2D6B5A3C, 96'h0};
		for (int t = 0; t < 32; t++) b[3*t +: 3] = 3'(t);
		go(b, 0);
	endtask : s_hi
	task automatic s_chroma;
		go(idx2(64'h5A3C9E710F2DB6E4, 2'h0), 1);
	endtask : s_chroma
	task automatic s_mix0;
		go(idx2(64'hC3A51E967B28D04F, 2'h2), 0);
	endtask : s_mix0
	task automatic s_mix1;
		go(idx2(64'hB6D249A1F03C8E57, 2'h1), 2);
	endtask : s_mix1
	task automatic s_alpha;
		go(idx2(64'h6123456789ABCDEF, 2'h3), 0);
	endtask : s_alpha
	task automatic s_soft;
		logic [127:0] b;
		logic [31:0] r;
		int k;
		b = idx2(64'hC3A51E967B28D04F, 2'h1);
		for (k = 0; k < 4; k++)
			bus(1'b1, 32'(`TBD_OFS_BLOCK) + 32'(4*k), b[32*k +: 32], r);
		bus(1'b1, 32'(`TBD_OFS_CTRL), 32'h111, r);
		k = 0;
		do begin
			bus(1'b0, 32'(`TBD_OFS_STATUS), 32'h0, r);
			k++;
		end while (r[1] !== 1'b1 && k < 20);
		cmp(r, 32'hE);
		rd(32'(`TBD_OFS_RESULT), ref_col(b, 5'h11));
		rd(32'(`TBD_OFS_CTRL), 32'h11);
		bus(1'b1, 32'h20, 32'hFFFFFFFF, r);
		rd(32'h20, 32'h0);
	endtask : s_soft
	// ---------------------------------------------------------------
	// clock, run and verdict
	// ---------------------------------------------------------------
	task automatic report_and_stop;
		if (n_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// whole run needs some 310 cycles; the ceiling leaves wide margin
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			report_and_stop();
		end
	end
	initial begin
		rst_b = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		s_hi();
		s_chroma();
		s_mix0();
		s_mix1();
		s_alpha();
		s_soft();
		report_and_stop();
	end
endmodule : texture_block_decoder_test
bind tbd_top tbd_chk i_chk (.CLK_SYS_I(CLK_SYS_I), .RST_B_I(RST_B_I),
	.REQ_VALID_I(REQ_VALID_I), .REQ_BLOCK_I(REQ_BLOCK_I),
	.REQ_TEXEL_I(REQ_TEXEL_I), .RSP_VALID_O(RSP_VALID_O),
	.RSP_COLOUR_O(RSP_COLOUR_O), .RSP_MODE_O(RSP_MODE_O),
	.RSP_UNSUPP_O(RSP_UNSUPP_O));
